/* common/dhc_pkg.sv */
package dhc_pkg;
  localparam logic [15:0] KEY_VALUE      = 16'ha05f;
  localparam int          KEY_HI         = 31;
  localparam int          KEY_LO         = 16;
  localparam int          BIT_DEBUGEN    = 0;
  localparam int          BIT_HALT       = 1;
  localparam int          BIT_STEP       = 2;
  localparam int          BIT_MASKINTS   = 3;
  localparam int          BIT_REGRDY     = 16;
  localparam int          BIT_S_HALT     = 17;
  localparam int          BIT_SLEEP      = 18;
  localparam int          BIT_LOCKUP     = 19;
  localparam int          BIT_RETIRE     = 24;
  localparam int          BIT_RESET_ST   = 25;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;

  // access from the debug side
  typedef struct packed {
    logic        wr;       // write strobe
    logic        rd;       // read strobe
    logic        from_ext; // access from the external debug port
    logic [31:0] wdata;
  } dhc_acc_t;

  // core state seen by this block
  typedef struct packed {
    logic halted;
    logic sleeping;
    logic locked;
    logic retired;    // instruction completed this cycle
    logic core_reset; // processor reset seen this cycle
    logic sel_write;  // write to core register selector
    logic xfer_done;  // core register transfer finished
  } dhc_core_t;

  // control outputs to the core
  typedef struct packed {
    logic halt_req;
    logic step_en;
    logic mask_ints;
    logic debug_en;
  } dhc_ctrl_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HALT  = 2'b01
  } dhc_state_t;
endpackage

/* hw/dhc_sticky.sv */
`timescale 1ns/1ps
// sticky flag: set wins over read clear
module dhc_sticky (
  input  wire logic i_clock,   // system clock
  input  wire logic i_rst,     // synchronous reset, forces flag
  input  wire logic i_rst_val, // value taken on reset
  input  wire logic i_set,     // event
  input  wire logic i_clr,     // read clear
  output logic      o_flag     // flag value
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (i_clr) begin
      flag_next = 1'b0;
    end
    if (i_set) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flag_reg <= i_rst_val;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;
endmodule

/* hw/dhc_ctrl_wr.sv */
`timescale 1ns/1ps
// key check and control half update
module dhc_ctrl_wr (
  input  wire logic           i_clock,   // system clock
  input  wire logic           i_por,     // power-on reset
  input  wire dhc_pkg::dhc_acc_t i_acc,  // access
  output dhc_pkg::dhc_ctrl_t  o_ctrl     // stored control bits
);
  dhc_pkg::dhc_ctrl_t ctrl_reg;
  dhc_pkg::dhc_ctrl_t ctrl_next;
  logic               key_ok;

  assign key_ok = i_acc.wdata[dhc_pkg::KEY_HI:dhc_pkg::KEY_LO]
                  == dhc_pkg::KEY_VALUE;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (i_acc.wr && key_ok) begin
      ctrl_next.halt_req  = i_acc.wdata[dhc_pkg::BIT_HALT];
      ctrl_next.step_en   = i_acc.wdata[dhc_pkg::BIT_STEP];
      ctrl_next.mask_ints = i_acc.wdata[dhc_pkg::BIT_MASKINTS];
      if (i_acc.from_ext) begin
        ctrl_next.debug_en = i_acc.wdata[dhc_pkg::BIT_DEBUGEN];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_por) begin
      ctrl_reg <= dhc_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign o_ctrl = ctrl_reg;

  a_key_guard: assert property (@(posedge i_clock) disable iff (i_por)
    (i_acc.wr && !key_ok) |=> $stable(ctrl_reg))
    else $error("control changed without key");
  a_en_ext_only: assert property (@(posedge i_clock) disable iff (i_por)
    (i_acc.wr && !i_acc.from_ext) |=> $stable(ctrl_reg.debug_en))
    else $error("enable changed by core write");
endmodule

/* hw/dhc_top.sv */
`timescale 1ns/1ps
module dhc_top (
  input  wire logic               i_clock,     // 200 MHz clock
  input  wire logic               i_sys_rst,   // sync reset, local
  input  wire logic               i_por,       // sync power-on reset
  input  wire dhc_pkg::dhc_acc_t  i_acc,       // register access
  input  wire dhc_pkg::dhc_core_t i_core,      // core status
  output logic [31:0]             o_rdata,     // read data
  output dhc_pkg::dhc_ctrl_t      o_ctrl,      // effective controls
  output logic                    o_debug_state // in debug state
);
  dhc_pkg::dhc_ctrl_t ctrl_raw;
  dhc_pkg::dhc_state_t st_reg;
  dhc_pkg::dhc_state_t st_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rdy_reg;
  logic        rdy_next;
  logic        lock_reg;
  logic        lock_next;
  logic        reset_flag;
  logic        retire_flag;
  logic        entering;

  dhc_ctrl_wr u_ctrl (
    .i_clock (i_clock),
    .i_por   (i_por),
    .i_acc   (i_acc),
    .o_ctrl  (ctrl_raw)
  );

  dhc_sticky u_reset_st (
    .i_clock   (i_clock),
    .i_rst     (i_por),
    .i_rst_val (1'b1),
    .i_set     (i_core.core_reset | i_sys_rst),
    .i_clr     (i_acc.rd),
    .o_flag    (reset_flag)
  );

  dhc_sticky u_retire_st (
    .i_clock   (i_clock),
    .i_rst     (i_por),
    .i_rst_val (1'b0),
    .i_set     (i_core.retired && st_reg == dhc_pkg::ST_RUN),
    .i_clr     (i_acc.rd),
    .o_flag    (retire_flag)
  );

  // controls reach the core only while halting debug is enabled
  always_comb begin
    o_ctrl = '0;
    if (ctrl_raw.debug_en) begin
      o_ctrl = ctrl_raw;
    end
  end

  assign entering = (st_reg == dhc_pkg::ST_RUN) && i_core.halted;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      dhc_pkg::ST_RUN: begin
        if (i_core.halted) begin
          st_next = dhc_pkg::ST_HALT;
        end
      end
      dhc_pkg::ST_HALT: begin
        if (!i_core.halted) begin
          st_next = dhc_pkg::ST_RUN;
        end
      end
      default: st_next = dhc_pkg::ST_RUN;
    endcase
  end

  always_comb begin
    rdy_next = rdy_reg;
    if (i_core.sel_write) begin
      rdy_next = 1'b0;
    end
    if (i_core.xfer_done) begin
      rdy_next = 1'b1;
    end
    lock_next = i_core.locked;
    if (entering || i_core.halted) begin
      lock_next = 1'b0;
    end
  end

  // read image, reserved bits zero, key never returned
  always_comb begin
    rdata_next = rdata_reg;
    if (i_acc.rd) begin
      rdata_next = '0;
      rdata_next[dhc_pkg::BIT_RESET_ST] = reset_flag;
      rdata_next[dhc_pkg::BIT_RETIRE]   = retire_flag;
      rdata_next[dhc_pkg::BIT_LOCKUP]   = lock_reg && i_acc.from_ext;
      rdata_next[dhc_pkg::BIT_SLEEP]    = i_core.sleeping;
      rdata_next[dhc_pkg::BIT_S_HALT]   = st_reg == dhc_pkg::ST_HALT;
      rdata_next[dhc_pkg::BIT_REGRDY]   = rdy_reg;
      rdata_next[dhc_pkg::BIT_DEBUGEN]  = ctrl_raw.debug_en;
      rdata_next[dhc_pkg::BIT_HALT]     = ctrl_raw.halt_req;
      rdata_next[dhc_pkg::BIT_STEP]     = ctrl_raw.step_en;
      rdata_next[dhc_pkg::BIT_MASKINTS] = ctrl_raw.mask_ints;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_por) begin
      st_reg    <= dhc_pkg::ST_RUN;
      rdata_reg <= '0;
      rdy_reg   <= 1'b0;
      lock_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      rdata_reg <= rdata_next;
      rdy_reg   <= rdy_next;
      lock_reg  <= lock_next;
    end
  end

  assign o_rdata       = rdata_reg;
  assign o_debug_state = st_reg == dhc_pkg::ST_HALT;

  a_halt_follow: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    i_core.halted |=> o_debug_state)
    else $error("halted flag not set");
  a_reset_sticky: assert property (@(posedge i_clock)
    disable iff (i_por)
    i_core.core_reset |=> reset_flag)
    else $error("reset flag lost");
  a_retire_set: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    (i_core.retired && !o_debug_state) |=> retire_flag)
    else $error("retire flag not set");
  a_read_clear: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    (i_acc.rd && !i_core.retired) |=> !retire_flag)
    else $error("retire flag not cleared");
  a_lock_port: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    (i_acc.rd && !i_acc.from_ext) |=> !o_rdata[dhc_pkg::BIT_LOCKUP])
    else $error("lockup visible to core");
  a_lock_entry: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    entering |=> !lock_reg)
    else $error("lockup not cleared");
  a_rdy_clear: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    (i_core.sel_write && !i_core.xfer_done) |=> !rdy_reg)
    else $error("ready not cleared");
  a_rdy_set: assert property (@(posedge i_clock)
    disable iff (i_sys_rst || i_por)
    i_core.xfer_done |=> rdy_reg)
    else $error("ready not set");
  a_en_gate: assert property (@(posedge i_clock)
    disable iff (i_por)
    !ctrl_raw.debug_en |-> (o_ctrl == '0))
    else $error("controls leak while disabled");

  c_halt_entry: cover property (@(posedge i_clock) entering);
  c_xfer: cover property (@(posedge i_clock)
    i_core.sel_write ##[1:20] i_core.xfer_done);
  c_read_retire: cover property (@(posedge i_clock)
    i_acc.rd && i_core.retired);
endmodule

/* tb/dhc_core_model.sv */
`timescale 1ns/1ps
// core stand-in: halts on request, finishes transfers after 3 cycles
module dhc_core_model (
  input  wire logic               i_clock,   // system clock
  input  wire logic               i_sys_rst, // local reset
  input  wire dhc_pkg::dhc_ctrl_t i_ctrl,    // effective controls
  input  wire logic [3:0]         i_cmd,     // go, sleep, lock, sel
  output dhc_pkg::dhc_core_t      o_core     // core status
);
  logic       halt_reg;
  logic       halt_next;
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  always_comb begin
    halt_next = i_ctrl.halt_req;
    sel_next  = {sel_reg[1:0], i_cmd[0]};
    if (i_sys_rst) begin
      halt_next = 1'h0;
      sel_next  = 3'h0;
    end
  end
  always_ff @(posedge i_clock) begin
    halt_reg <= halt_next;
    sel_reg  <= sel_next;
  end
  // lockup level kept in debug state, the block must hide it
  assign o_core = '{halt_reg, i_cmd[2], i_cmd[1],
                    i_cmd[3] & !halt_reg, 1'h0, i_cmd[0], sel_reg[2]};
endmodule

/* tb/test_dhc_top.sv */
`timescale 1ns/1ps
module test_dhc_top;
  localparam logic [31:0] K = 32'ha05f_0000;
  logic               i_clock = 1'h0;
  logic               i_sys_rst = 1'h1;
  logic               i_por = 1'h1;
  dhc_pkg::dhc_acc_t  acc = '0;
  dhc_pkg::dhc_core_t core;
  dhc_pkg::dhc_ctrl_t ctrl;
  logic [31:0]        rdata;
  logic [31:0]        d;
  logic               dbg;
  logic [3:0]         cmd = 4'h0;
  int                 fail_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  always #2.5 i_clock = ~i_clock;
  dhc_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_por(i_por),
    .i_acc(acc), .i_core(core), .o_rdata(rdata), .o_ctrl(ctrl),
    .o_debug_state(dbg));
  dhc_core_model core_m (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_ctrl(ctrl), .i_cmd(cmd), .o_core(core));
  task wrap_up;
    $display("mismatches %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic ext, input logic [31:0] v);
    @(posedge i_clock) acc <= '{1'h1, 1'h0, ext, v};
    @(posedge i_clock) acc <= '0;
    #1;
  endtask
  task rd(input logic ext);
    @(posedge i_clock) acc <= '{1'h0, 1'h1, ext, 32'h0};
    @(posedge i_clock) acc <= '0;
    #1 d = rdata;
  endtask
  task put(input logic [3:0] c);
    @(posedge i_clock) cmd <= c;
  endtask
  task wait_dbg(input logic v);
    for (int i = 0; i < 10 && dbg !== v; i++) @(posedge i_clock);
    #1 chk({31'h0, dbg}, {31'h0, v});
  endtask
  task s_reset;
    rd(1'h1);
    chk(d, 32'h0200_0000);
    rd(1'h1);
    chk(d, 32'h0);
  endtask
  task s_key;
    wr(1'h1, 32'h0000_0003);
    chk({28'h0, ctrl}, 32'h0);
    wr(1'h0, K | 32'h1);
    chk({28'h0, ctrl}, 32'h0);
    wr(1'h1, K | 32'h2);
    chk({28'h0, ctrl}, 32'h0);
    wr(1'h1, K | 32'h1);
    chk({28'h0, ctrl}, 32'h1);
  endtask
  task s_halt;
    put(4'h2);
    wr(1'h1, K | 32'h3);
    wait_dbg(1'h1);
    rd(1'h1);
    chk(d & 32'h000a_0000, 32'h0002_0000);
    wr(1'h1, K | 32'hf);
    chk({28'h0, ctrl}, 32'hf);
    put(4'h1);
    put(4'h0);
    rd(1'h1);
    chk(d & 32'h0001_0000, 32'h0);
    repeat (4) @(posedge i_clock);
    rd(1'h1);
    chk(d & 32'h0001_000f, 32'h0001_000f);
    put(4'h1);
    put(4'h0);
    rd(1'h1);
    chk(d & 32'h0001_0000, 32'h0);
    wr(1'h1, K | 32'h3);
    wr(1'h1, K | 32'h1);
    wait_dbg(1'h0);
  endtask
  task s_lock;
    put(4'h6);
    rd(1'h1);
    chk(d & 32'h000e_0000, 32'h000c_0000);
    rd(1'h0);
    chk(d & 32'h0008_0000, 32'h0);
    put(4'h0);
    rd(1'h1);
    chk(d & 32'h000c_0000, 32'h0);
    put(4'h4);
    wr(1'h1, K | 32'h3);
    wait_dbg(1'h1);
    rd(1'h1);
    chk(d & 32'h0006_0000, 32'h0006_0000);
    wr(1'h1, K | 32'h1);
    wait_dbg(1'h0);
    put(4'h0);
  endtask
  task s_retire;
    rd(1'h1);
    put(4'h8);
    repeat (3) @(posedge i_clock);
    rd(1'h1);
    chk(d & 32'h0100_0000, 32'h0100_0000);
    put(4'h0);
    rd(1'h1);
    chk(d & 32'h0100_0000, 32'h0100_0000);
    rd(1'h1);
    chk(d & 32'h0100_0000, 32'h0);
    @(posedge i_clock) i_sys_rst <= 1'h1;
    @(posedge i_clock) i_sys_rst <= 1'h0;
    rd(1'h1);
    chk(d & 32'h0200_0000, 32'h0200_0000);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_sys_rst <= 1'h0;
    i_por <= 1'h0;
    s_reset();
    s_key();
    s_halt();
    s_lock();
    s_retire();
    wrap_up();
  end
endmodule
